/* hw/xie_pkg.sv */
// Purpose: Shared constants and carriers for the exclusive-OR execute block
// Assumes: 14-bit instruction words, 8-bit data path, 7-bit file address
// Notes:   Opcode and destination encodings and their field positions live here

package xie_pkg;

    // ****************************************************************
    // Instruction fields
    // ****************************************************************
    localparam int          INSN_W        = 14;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 7;
    localparam int          OPC_MSB       = 13;
    localparam int          OPC_LSB       = 8;
    localparam int          DEST_BIT      = 7;
    localparam logic [5:0]  OPC_XOR_LIT   = 6'h3A;
    localparam logic [5:0]  OPC_XOR_FILE  = 6'h06;
    localparam logic        DEST_ACC      = 1'h0;
    localparam logic        DEST_FILE     = 1'h1;

    // ****************************************************************
    // Reset values and timing
    // ****************************************************************
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic        ZERO_RESET    = 1'h0;
    localparam int          EXEC_CYCLES   = 1;

    // File register write request towards the data memory
    typedef struct packed {
        logic        we;
        logic [6:0]  addr;
        logic [7:0]  data;
    } xie_file_wr_t;

endpackage : xie_pkg

/* hw/xie_execute.sv */
// Purpose: Decode and execute the two exclusive-OR instructions of the core
// Assumes: One instruction per enabled clock; file data arrives combinationally
// Notes:   Other opcodes leave accumulator and zero flag untouched and clear write enable and completion pulse
//
// Operation
// RL1 - Opcode 111010 selects literal form; low eight bits are the literal.
// RL2 - Literal form: accumulator XOR literal into accumulator, one cycle.
// RL3 - Opcode 000110 selects file form; bit 7 destination, bits 6..0 address.
// RL4 - File form, destination 0: result into accumulator, file unchanged.
// RL5 - File form, destination 1: result into file, accumulator unchanged.
// RL6 - Zero flag follows result; carry and digit carry untouched.

`timescale 1ns/100ps

module xie_execute (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 ce_i,
    // Instruction stream
    input  wire logic                 insn_valid_i,
    input  wire logic [13:0]          insn_i,
    // File register read port
    output logic      [6:0]           file_raddr_o,
    input  wire logic [7:0]           file_rdata_i,
    // File register write request
    output xie_pkg::xie_file_wr_t     file_wr_o,
    // Core state
    output logic      [7:0]           acc_o,
    output logic                      zero_o,
    output logic                      xor_exec_o
);

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire logic [5:0] opcode     = insn_i[xie_pkg::OPC_MSB:xie_pkg::OPC_LSB];
    wire logic [7:0] literal    = insn_i[7:0];                          // RL1
    wire logic       dest_sel   = insn_i[xie_pkg::DEST_BIT];            // RL3
    wire logic [6:0] file_addr  = insn_i[6:0];                          // RL3
    wire logic       is_lit     = insn_valid_i && ce_i
                                  && (opcode == xie_pkg::OPC_XOR_LIT);  // RL1
    wire logic       is_file    = insn_valid_i && ce_i
                                  && (opcode == xie_pkg::OPC_XOR_FILE); // RL3
    wire logic [7:0] operand    = is_lit ? literal : file_rdata_i;
    wire logic [7:0] result     = acc_o ^ operand;                      // RL2
    wire logic       to_acc     = is_lit
                                  || (is_file && dest_sel == xie_pkg::DEST_ACC); // RL4
    wire logic       to_file    = is_file && dest_sel == xie_pkg::DEST_FILE;    // RL5
    wire logic       result_z   = (result == 8'h00);                    // RL6

    assign file_raddr_o = file_addr;

    // ****************************************************************
    // State
    // ****************************************************************
    // Accumulator, zero flag and write request all update in the same edge,
    // so each instruction completes in one cycle with no stall.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_o      <= xie_pkg::ACC_RESET;
            zero_o     <= xie_pkg::ZERO_RESET;
            file_wr_o  <= '0;
            xor_exec_o <= 1'h0;
        end else if (ce_i) begin
            if (to_acc) begin
                acc_o <= result;                                        // RL2
            end
            if (is_lit || is_file) begin
                zero_o <= result_z;                                     // RL6
            end
            file_wr_o.we   <= to_file;                                  // RL5
            file_wr_o.addr <= file_addr;
            file_wr_o.data <= result;
            xor_exec_o     <= is_lit || is_file;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_lit_acc_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        is_lit |=> acc_o == ($past(acc_o) ^ $past(literal)))
        else $error("literal form wrong accumulator");

    a_file_acc_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
        (is_file && !dest_sel) |=> acc_o == ($past(acc_o) ^ $past(file_rdata_i))
                                   && !file_wr_o.we)
        else $error("file form to accumulator wrong");

    a_file_writeback: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL5
        (is_file && dest_sel) |=> file_wr_o.we && acc_o == $past(acc_o)
            && file_wr_o.data == ($past(acc_o) ^ $past(file_rdata_i))
            && file_wr_o.addr == $past(file_addr))
        else $error("file writeback wrong");

    a_zero_flag_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        (is_lit || is_file) |=> zero_o == ($past(result) == 8'h00))
        else $error("zero flag mismatch");

    a_lit_decode_only: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
        (ce_i && insn_valid_i && opcode == 6'h3A) |=> xor_exec_o)
        else $error("literal opcode not taken");

    a_file_decode_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL3
        (ce_i && insn_valid_i && opcode == 6'h06) |=> xor_exec_o
            && file_wr_o.addr == $past(insn_i[6:0]))
        else $error("file opcode not taken");

    a_other_op_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
        (ce_i && !is_lit && !is_file) |=> $stable(acc_o) && $stable(zero_o)
                                          && !file_wr_o.we && !xor_exec_o)
        else $error("state changed on other opcode");

    a_freeze_on_ce: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        !ce_i |=> $stable(acc_o) && $stable(zero_o) && $stable(file_wr_o))
        else $error("state moved while disabled");

    // ****************************************************************
    // Decode checks
    // ****************************************************************
    // Decode must follow the package encodings exactly, with no overlap
    a_lit_decode_exact: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
        (ce_i && insn_valid_i && insn_i[13:8] == xie_pkg::OPC_XOR_LIT)
            |-> is_lit)
        else $error("literal decode missed");

    a_file_decode_exact: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL3
        (ce_i && insn_valid_i && insn_i[13:8] == xie_pkg::OPC_XOR_FILE)
            |-> is_file)
        else $error("file decode missed");

    a_forms_exclusive: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL3
        !(is_lit && is_file))
        else $error("both forms decoded");

    a_raddr_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL3
        file_raddr_o == insn_i[6:0])
        else $error("read address not from word");

    a_dest_acc_path: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
        (is_file && !insn_i[7])
            |-> (to_acc && !to_file))
        else $error("destination zero misrouted");

    a_dest_file_path: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL5
        (is_file && insn_i[7])
            |-> (to_file && !to_acc))
        else $error("destination one misrouted");

    // ****************************************************************
    // Write request checks
    // ****************************************************************
    // The memory applies any cycle with we high, so a stray pulse corrupts a file
    a_lit_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        is_lit
            |=> !file_wr_o.we)
        else $error("literal form wrote a file");

    a_acc_dest_no_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL4
        (ce_i && !to_file)
            |=> !file_wr_o.we)
        else $error("write without file destination");

    a_file_dest_acc_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL5
        to_file
            |=> $stable(acc_o))
        else $error("accumulator moved on file destination");

    a_no_valid_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL1
        (ce_i && !insn_valid_i)
            |=> (!xor_exec_o && !file_wr_o.we && $stable(acc_o) && $stable(zero_o)))
        else $error("state moved without instruction");

    // ****************************************************************
    // Zero flag checks
    // ****************************************************************
    // Operands or written data compared directly so the checks do not lean on result_z
    a_lit_zero_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        (is_lit && acc_o == literal)
            |=> zero_o)
        else $error("literal zero not set");

    a_lit_zero_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        (is_lit && acc_o != literal)
            |=> !zero_o)
        else $error("literal zero not cleared");

    a_file_zero_set: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        (is_file && acc_o == file_rdata_i)
            |=> zero_o)
        else $error("file zero not set");

    a_file_zero_clr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        (is_file && acc_o != file_rdata_i)
            |=> !zero_o)
        else $error("file zero not cleared");

    a_wr_zero_match: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL6
        to_file
            |=> (zero_o == (file_wr_o.data == 8'h00)))
        else $error("zero flag disagrees with written data");

    // ****************************************************************
    // Completion pulse checks
    // ****************************************************************
    a_exec_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        (is_lit || is_file)
            |=> xor_exec_o)
        else $error("completion pulse missing");

    a_exec_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        !ce_i
            |=> $stable(xor_exec_o))
        else $error("completion pulse moved while disabled");

    a_exec_single: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RL2
        (ce_i && xor_exec_o && !is_lit && !is_file)
            |=> !xor_exec_o)
        else $error("completion pulse stretched");

endmodule : xie_execute

/* dv/xie_execute_tb.sv */
// Purpose: Self-checking bench for the exclusive-OR execute block
// Assumes: Bench acts as instruction fetch and file memory
// Notes:   Each instruction takes two cycles so no word is sampled twice
`timescale 1ns/100ps
module xie_execute_tb;
    logic                  clk_i, rst_n_i, ce_i, insn_valid_i;
    logic [13:0]           insn_i;
    logic [7:0]            file_rdata_i, acc_o;
    logic [6:0]            file_raddr_o;
    logic                  zero_o, xor_exec_o;
    xie_pkg::xie_file_wr_t file_wr_o;
    int                    mismatches = 0;
    int                    checked = 0;
    xie_execute dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .insn_valid_i(insn_valid_i), .insn_i(insn_i), .file_raddr_o(file_raddr_o),
        .file_rdata_i(file_rdata_i), .file_wr_o(file_wr_o), .acc_o(acc_o),
        .zero_o(zero_o), .xor_exec_o(xor_exec_o));
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (e !== g) begin
            $display("Error %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk
    // Drive one word, then drop valid at the taking edge and check after it
    task automatic step(input logic [13:0] w, input logic [7:0] rd, input logic ce);
        @(posedge clk_i);
        insn_i <= w; file_rdata_i <= rd; ce_i <= ce; insn_valid_i <= 1'h1;
        @(posedge clk_i);
        insn_valid_i <= 1'h0; ce_i <= 1'h1;
        #1;
    endtask : step
    task automatic t_lit();
        step(14'h3AB5, 8'h00, 1'h1);
        chk("acc", 16'h00B5, acc_o);
        step(14'h3AAF, 8'h00, 1'h1);
        chk("acc", 16'h001A, acc_o);
        chk("exec", 16'h0001, xor_exec_o);
        chk("we", 16'h0000, file_wr_o.we);
        step(14'h3A1A, 8'h00, 1'h1);
        chk("zero", 16'h0003, {acc_o == 8'h00, zero_o});
        $display("t_lit done");
    endtask : t_lit
    task automatic t_file();
        step(14'h3AB5, 8'h00, 1'h1);
        step(14'h06FF, 8'hAF, 1'h1);
        chk("raddr", 16'h007F, file_raddr_o);
        chk("file_wr", 16'hFF1A, file_wr_o);
        chk("acc", 16'h00B5, acc_o);
        chk("zero", 16'h0000, zero_o);
        step(14'h0600, 8'hB5, 1'h1);
        chk("acc", 16'h0000, acc_o);
        chk("we", 16'h0000, file_wr_o.we);
        chk("zero", 16'h0001, zero_o);
        $display("t_file done");
    endtask : t_file
    task automatic t_refuse();
        step(14'h3A5A, 8'h00, 1'h1);
        step(14'h0E5A, 8'h00, 1'h1);
        chk("exec", 16'h0000, xor_exec_o);
        chk("acc", 16'h005A, acc_o);
        step(14'h3A5A, 8'h00, 1'h0);
        chk("acc", 16'h005A, acc_o);
        chk("exec", 16'h0000, xor_exec_o);
        $display("t_refuse done");
    endtask : t_refuse
    task automatic close_out();
        $display("Checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    initial begin
        rst_n_i = 1'h0; ce_i = 1'h1; insn_valid_i = 1'h0;
        insn_i = 14'h0000; file_rdata_i = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'h1;
        t_lit();
        t_file();
        t_refuse();
        close_out();
    end
    // Hang guard, far beyond the few dozen cycles the tests need
    initial begin
        repeat (2000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule : xie_execute_tb
